// File: rtl/guard_eval_ctrl.sv
// Guard evaluation controller: teach-in, code compare, relay and LEDs
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Teach-in forces both relays and door monitor outputs low.
// - Unit without a code flashes green at about 4 Hz.
// - Actuator in range while waiting starts teach-in, green flashes 1 Hz.
// - Teach-in ends after 60 s; green off, new code stored, old retired.
// - Same actuator cannot be taught twice; at most 8 teach-ins.
// - Only the most recently taught code enables the outputs.
// - Aborted or power-failed teach-in is invalid; old code kept.
// - At power-on green blinks the number of remaining teach-ins.
// - After eighth or with old actuator: 60 s teach mode, code unchanged.
// - Test input active turns relays off and raises diagnostic output.
// - Test input released clears diagnostic, red off, relays back on.
// - Manual start needs a fresh start press after a test cycle.
// - Each active head drives its door monitor output high on code match.
// - Relays and guard LED on only when all active heads match.
// - Open guard drops relays and guard LED; door outputs keep reporting.
// - Internal fault switches off, raises diagnostic, lights red LED.
// - Manual start accepted only on a falling edge of the start input.
// - With feedback mode, start needs the feedback loop closed.
// - During ready delay relays are off and door outputs low.
// - Relays drop within 180 ms of actuator removal.
module guard_eval_ctrl #(
    parameter int PRESCALE_CYC = guard_pkg::PRESCALE
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire guard_pkg::head_t [guard_pkg::HEADS-1:0] head_i,
    input wire logic guard_test_input_i,
    input wire logic start_button_i,
    input wire logic feedback_closed_i,
    input wire logic internal_fault_i,
    input wire logic [guard_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output guard_pkg::out_t out_o,
    output logic [guard_pkg::HEADS-1:0] door_monitor_o
);
    import guard_pkg::*;

    localparam logic [MS_W-1:0] TEACH_TICKS = MS_W'(TEACH_MS);
    localparam logic [MS_W-1:0] READY_TICKS = MS_W'(READY_MS);
    localparam logic [CNT_W-1:0] MAX_CNT = CNT_W'(MAX_TEACH);
    localparam int PRE_W = $clog2(PRESCALE_CYC + 1);

    // Code hit test against the list of already taught actuators
    function automatic logic code_known(
        input logic [CODE_W-1:0] c,
        input logic [CODE_W-1:0] mem [MAX_TEACH],
        input logic [CNT_W-1:0] n
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < MAX_TEACH; i++) begin
            if (CNT_W'(i) < n && mem[i] == c) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : code_known

    // Teach memory survives reset (non-volatile in the device)
    logic [CODE_W-1:0] taught_mem [MAX_TEACH];
    logic [CNT_W-1:0] taught_cnt;
    logic [CODE_W-1:0] pending_code;
    logic [CODE_W-1:0] active_code;
    logic active_valid;

    ctl_state_t state;
    ctl_state_t next_state;
    cfg_t cfg;
    logic [PRE_W-1:0] pre_cnt;
    logic tick;
    logic [MS_W-1:0] ms_cnt;
    logic [MS_W-1:0] blink_cnt;
    logic teach_real;
    logic [CODE_W-1:0] teach_code;
    logic teach_invalid;
    logic run_on;
    logic start_q;
    logic fault_seen;

    // Bus decode
    wire wr_ctrl = wr_i && addr_i == CTRL_OFS;
    wire mem_clear = wr_ctrl && wdata_i[CTRL_CLEAR_BIT];

    // Millisecond tick prescaler
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_cnt <= '0;
            tick <= 1'b0;
        end else if (pre_cnt == PRE_W'(PRESCALE_CYC - 1)) begin
            pre_cnt <= '0;
            tick <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // State timer restarts on each state change; free blink counter
    wire state_chg = next_state != state;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ms_cnt <= '0;
            blink_cnt <= '0;
        end else begin
            if (state_chg) begin
                ms_cnt <= '0;
            end else if (tick && ms_cnt != '1) begin
                ms_cnt <= ms_cnt + 1'b1;
            end
            if (tick) begin
                blink_cnt <= (blink_cnt == MS_W'(SLOW_PERIOD_MS - 1)) ?
                    '0 : blink_cnt + 1'b1;
            end
        end
    end

    // Head compare and arming conditions
    wire [HEADS-1:0] head_en = HEADS'((5'h2 << cfg.heads_m1) - 5'h1);
    logic [HEADS-1:0] match;
    logic [HEADS-1:0] foreign;
    always_comb begin
        for (int h = 0; h < HEADS; h++) begin
            match[h] = head_en[h] && head_i[h].present && active_valid &&
                head_i[h].code == active_code;
            foreign[h] = head_en[h] && head_i[h].present &&
                !(active_valid && head_i[h].code == active_code);
        end
    end
    wire all_match = (match | ~head_en) == '1;
    wire any_foreign = |foreign;
    wire [CODE_W-1:0] foreign_code = head_i[0].present ? head_i[0].code :
        head_i[1].present ? head_i[1].code :
        head_i[2].present ? head_i[2].code : head_i[3].code;
    wire foreign_old = code_known(foreign_code, taught_mem, taught_cnt);
    wire teach_left_none = taught_cnt >= MAX_CNT;
    wire teach_ends = tick && ms_cnt == TEACH_TICKS - 1'b1;

    // Control state sequence
    always_comb begin
        next_state = state;
        case (state)
            st_powerup: begin
                if (tick && ms_cnt == READY_TICKS - 1'b1) begin
                    next_state = active_valid ? st_run : st_first_wait;
                end
            end
            st_first_wait: begin
                if (head_i[0].present) begin
                    next_state = st_teach;
                end
            end
            st_run: begin
                if (any_foreign) begin
                    next_state = st_teach;
                end
            end
            st_teach: begin
                if (!head_i[0].present && !any_foreign) begin
                    next_state = active_valid ? st_run : st_first_wait;
                end else if (teach_ends) begin
                    next_state = st_done;
                end
            end
            st_done: next_state = st_done;
            default: next_state = st_powerup;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= st_powerup;
        end else begin
            state <= next_state;
        end
    end

    // Teach session bookkeeping
    wire teach_start = next_state == st_teach && state != st_teach;
    wire teach_abort = state == st_teach && next_state != st_teach &&
        next_state != st_done;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            teach_real <= 1'b0;
            teach_code <= '0;
            teach_invalid <= 1'b0;
        end else begin
            if (teach_start) begin
                teach_code <= state == st_first_wait ? head_i[0].code :
                    foreign_code;
                teach_real <= !teach_left_none && !(state == st_first_wait ?
                    code_known(head_i[0].code, taught_mem, taught_cnt) :
                    foreign_old);
            end
            if (teach_abort) begin
                teach_invalid <= 1'b1;
            end
        end
    end

    // Non-volatile teach store; only a finished real teach or mem_clear writes it
    always_ff @(posedge sys_clk_i) begin
        if (mem_clear) begin
            taught_cnt <= '0;
            pending_code <= '0;
        end else if (state == st_teach && next_state == st_done &&
                     teach_real) begin
            taught_mem[taught_cnt[2:0]] <= teach_code;
            pending_code <= teach_code;
            taught_cnt <= taught_cnt + 1'b1;
        end
    end

    // Stored code becomes active only through a power cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            active_code <= '0;
            active_valid <= 1'b0;
        end else if (mem_clear) begin
            active_code <= '0;
            active_valid <= 1'b0;
        end else if (state == st_powerup) begin
            active_code <= pending_code;
            active_valid <= taught_cnt != '0;
        end
    end

    // Configuration register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg <= '{heads_m1: CTRL_HEADS_RST, manual: 1'b0, fb_mode: 1'b0};
        end else if (wr_ctrl) begin
            cfg.heads_m1 <= wdata_i[CTRL_HEADS_LSB +: 2];
            cfg.manual <= wdata_i[CTRL_MANUAL_BIT];
            cfg.fb_mode <= wdata_i[CTRL_FB_BIT];
        end
    end

    // Start edge, sticky internal fault
    wire start_fall = start_q && !start_button_i;
    wire fb_ok = !cfg.fb_mode || feedback_closed_i;
    wire start_req = cfg.manual ? start_fall : 1'b1;
    wire block_run = state != st_run || !all_match || guard_test_input_i ||
        fault_seen || internal_fault_i;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_q <= 1'b0;
            fault_seen <= 1'b0;
            run_on <= 1'b0;
        end else begin
            start_q <= start_button_i;
            if (internal_fault_i) begin
                fault_seen <= 1'b1;
            end
            if (block_run) begin
                run_on <= 1'b0;
            end else if (!run_on && start_req && fb_ok) begin
                run_on <= 1'b1;
            end
        end
    end

    // Indicator patterns
    wire fast_on = (blink_cnt % MS_W'(2 * FAST_HALF_MS)) <
        MS_W'(FAST_HALF_MS);
    wire slow_on = blink_cnt < MS_W'(SLOW_HALF_MS);
    wire [MS_W-1:0] slot = ms_cnt / MS_W'(COUNT_SLOT_MS);
    wire [CNT_W-1:0] left = teach_left_none ? '0 : MAX_CNT - taught_cnt;
    wire count_on = slot[0] && (slot >> 1) < MS_W'(left);
    logic green;
    always_comb begin
        case (state)
            st_powerup: green = count_on;
            st_first_wait: green = fast_on;
            st_teach: green = slow_on;
            st_done: green = 1'b0;
            st_run: green = 1'b1;
            default: green = 1'b0;
        endcase
    end
    wire next_diag = guard_test_input_i || fault_seen ||
        internal_fault_i;
    wire next_run = run_on && !block_run;

    // Registered outputs
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_o <= '0;
            door_monitor_o <= '0;
        end else begin
            out_o.relay_a <= next_run;
            out_o.relay_b <= next_run;
            out_o.led_out <= next_run;
            out_o.diag <= next_diag;
            out_o.led_red <= next_diag || teach_invalid;
            out_o.led_green <= green;
            door_monitor_o <= (state == st_run) ? match : '0;
        end
    end

    // Read data, one cycle after the strobe
    wire [31:0] status_word = {20'h0, taught_cnt, 1'b0, state,
        teach_invalid, fault_seen, teach_real, run_on};
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                CTRL_OFS: rdata_o <= {28'h0, cfg.fb_mode, cfg.manual,
                    cfg.heads_m1};
                STATUS_OFS: rdata_o <= status_word;
                CODE_OFS: rdata_o <= {16'h0, active_code};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_teach_safe: assert property (
        state == st_teach |=> !out_o.relay_a && !out_o.relay_b &&
        door_monitor_o == '0)
        else $error("outputs active during teach-in");
    chk_ready_off: assert property (
        state == st_powerup |=> !out_o.relay_a && door_monitor_o == '0)
        else $error("outputs active during ready delay");
    chk_teach_len: assert property (
        state == st_teach && next_state == st_done |-> teach_ends)
        else $error("teach-in ended at wrong time");
    chk_store_once: assert property (
        taught_cnt == MAX_CNT |=> taught_cnt == MAX_CNT || $past(mem_clear))
        else $error("teach count passed its limit");
    chk_test_off: assert property (
        guard_test_input_i |=> !out_o.relay_a && !out_o.relay_b && out_o.diag)
        else $error("test input did not drop relays");
    chk_test_clear: assert property (
        $fell(guard_test_input_i) && !fault_seen && !internal_fault_i
        |=> !out_o.diag)
        else $error("diagnostic stuck after test");
    chk_start_edge: assert property (
        cfg.manual && !run_on && $rose(run_on) == 1'b0 ##1 $rose(run_on)
        |-> $past(start_fall))
        else $error("manual start without falling edge");
    chk_fb_start: assert property (
        $rose(run_on) && cfg.fb_mode |-> $past(feedback_closed_i))
        else $error("start with open feedback loop");
    chk_match_door: assert property (
        state == st_run && $stable(state) |=> door_monitor_o == $past(match))
        else $error("door monitor disagrees with compare");
    chk_relay_pair: assert property (
        out_o.relay_a |-> out_o.relay_b && $past(all_match, 2))
        else $error("relays on without full match");
    chk_switch_off: assert property (
        state == st_run && !all_match |-> ##[1:2] !out_o.relay_a)
        else $error("relays late after removal");
    chk_fault_red: assert property (
        internal_fault_i |=> out_o.led_red && out_o.diag ##1 !out_o.relay_a)
        else $error("fault not indicated");

    cov_teach_done: cover property (state == st_teach ##1 state == st_done);
    cov_run: cover property ($rose(out_o.relay_a));
    cov_test: cover property (guard_test_input_i ##1 !guard_test_input_i);
    cov_abort: cover property ($rose(teach_invalid));
endmodule : guard_eval_ctrl

`default_nettype wire

// File: rtl/guard_pkg.sv
// Constants, types and register map of the guard evaluation controller
package guard_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_HZ = 1000;             // One tick per millisecond
    localparam int PRESCALE = CLK_HZ / TICK_HZ;
    localparam int HEADS = 4;
    localparam int CODE_W = 16;
    localparam int MAX_TEACH = 8;
    localparam int CNT_W = 4;
    // Times in milliseconds
    localparam int TEACH_MS = 60_000;
    localparam int READY_MS = 3_000;
    localparam int FAST_HALF_MS = 125;         // 4 Hz flash
    localparam int SLOW_HALF_MS = 500;         // 1 Hz flash
    localparam int SLOW_PERIOD_MS = 1_000;
    localparam int COUNT_SLOT_MS = 125;        // Remaining-count blink slot
    localparam int SWITCH_OFF_MS = 180;
    localparam int MS_W = 16;
    // Register bus
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] CODE_OFS = 4'h8;
    // Control register fields
    localparam int CTRL_HEADS_LSB = 0;         // Active heads minus one
    localparam int CTRL_MANUAL_BIT = 2;
    localparam int CTRL_FB_BIT = 3;
    localparam int CTRL_CLEAR_BIT = 4;         // Write 1: wipe teach memory
    localparam logic [1:0] CTRL_HEADS_RST = 2'h0;

    typedef enum logic [2:0] {
        st_powerup, st_first_wait, st_teach, st_done, st_run
    } ctl_state_t;

    typedef struct packed {
        logic present;                         // Actuator inside distance
        logic [CODE_W-1:0] code;
    } head_t;

    typedef struct packed {
        logic [1:0] heads_m1;
        logic manual;
        logic fb_mode;
    } cfg_t;

    typedef struct packed {
        logic relay_a;
        logic relay_b;
        logic diag;
        logic led_green;
        logic led_red;
        logic led_out;
    } out_t;
endpackage : guard_pkg

// File: verification/actuator_model.sv
// Behavioural coded actuator seen through one read head
`timescale 1ns/100ps
`default_nettype none
module actuator_model #(
    parameter int DWELL_CYC = 500
) (
    input wire logic sys_clk_i,
    input wire logic want_in_i,
    input wire logic [guard_pkg::CODE_W-1:0] code_i,
    output guard_pkg::head_t head_o
);
    import guard_pkg::*;
    head_t h = '0;
    int dwell = DWELL_CYC;

    // Presence moves only once the minimum dwell has passed
    always @(posedge sys_clk_i) begin
        if (dwell < DWELL_CYC) begin
            dwell <= dwell + 1;
        end
        if (want_in_i != h.present && dwell >= DWELL_CYC) begin
            h.present <= want_in_i;
            dwell <= 0;
        end
        // Out of range the code line shows a changing pattern
        if (want_in_i) begin
            h.code <= code_i;
        end else if (!h.present) begin
            h.code <= ~h.code;
        end
    end

    assign head_o = h;
endmodule : actuator_model
`default_nettype wire

// File: verification/safety_guard_evaluation_ctrl_tb.sv
// Self-checking bench for the guard evaluation controller
`timescale 1ns/100ps
`default_nettype none
module safety_guard_evaluation_ctrl_tb;
    import guard_pkg::*;
    localparam int DW = 500;
    localparam logic [CODE_W-1:0] CODE_A = 16'h5A3C;
    localparam logic [CODE_W-1:0] CODE_B = 16'hC3A5;
    typedef struct packed {
        logic h1;
        logic tst;
        logic rel;
        logic dg;
        logic [3:0] dm;
    } row_t;
    // Head 1, test input, relays, diag, door monitors
    localparam row_t ROWS [5] = '{8'hA3, 8'h01, 8'hA3, 8'hD3, 8'hA3};
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic gtest = 1'b0;
    logic start = 1'b0;
    logic fb = 1'b1;
    logic fault = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [HEADS-1:0] want = 4'h0;
    logic [CODE_W-1:0] hcode [HEADS];
    wire head_t [HEADS-1:0] head;
    logic [31:0] dut_rdata;
    out_t dut_out;
    logic [HEADS-1:0] dut_dm;
    logic [31:0] rdata_o;
    logic [31:0] rd_val;
    out_t out_o;
    logic [HEADS-1:0] door_monitor_o;
    logic g_prev = 1'b0;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t0;
    int n;

    // Actuator models, one per read head
    for (genvar g = 0; g < HEADS; g++) begin : g_act
        actuator_model #(.DWELL_CYC(DW)) act (.sys_clk_i(sys_clk_i),
            .want_in_i(want[g]), .code_i(hcode[g]), .head_o(head[g]));
    end

    guard_eval_ctrl #(.PRESCALE_CYC(1)) dut (.sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i), .head_i(head), .guard_test_input_i(gtest),
        .start_button_i(start), .feedback_closed_i(fb),
        .internal_fault_i(fault), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(dut_rdata), .out_o(dut_out),
        .door_monitor_o(dut_dm));

    // Clock and cycle count
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) cyc <= cyc + 1;

    // Outputs copied at the falling edge, where they are settled
    always @(negedge sys_clk_i) begin
        rdata_o <= dut_rdata;
        out_o <= dut_out;
        door_monitor_o <= dut_dm;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk1(input string what, input logic e, input logic got);
        samples_checked++;
        if (got !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, got);
        end
    endtask : chk1

    task automatic chk32(input string what, input logic [31:0] e,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask : chk32

    task automatic settle(input int c);
        repeat (c) @(posedge sys_clk_i);
    endtask : settle

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        @(posedge sys_clk_i);
        rd_val = rdata_o;
    endtask : bus_rd

    task automatic wait_state(input logic [2:0] s, input int lim);
        int i;
        i = 0;
        do begin
            bus_rd(STATUS_OFS);
            i++;
        end while (rd_val[6:4] !== s && i < lim);
        chk32("state", {29'h0, s}, {29'h0, rd_val[6:4]});
    endtask : wait_state

    // Edges between two changes of the green indicator
    task automatic meas_green(output int cnt);
        logic g;
        int i;
        i = 0;
        @(posedge sys_clk_i);
        g = out_o.led_green;
        while (out_o.led_green === g && i < 3000) begin
            @(posedge sys_clk_i);
            i++;
        end
        g = out_o.led_green;
        cnt = 0;
        while (out_o.led_green === g && cnt < 3000) begin
            @(posedge sys_clk_i);
            cnt++;
        end
    endtask : meas_green

    task automatic chk_outs(input logic rel, input logic dg,
                            input logic [3:0] dm);
        chk1("relay_a", rel, out_o.relay_a);
        chk1("relay_b", rel, out_o.relay_b);
        chk1("led_out", rel, out_o.led_out);
        chk1("diag", dg, out_o.diag);
        chk32("door_monitor", {28'h0, dm}, {28'h0, door_monitor_o});
    endtask : chk_outs

    task automatic power_cycle();
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
    endtask : power_cycle

    task automatic pulse_test();
        gtest <= 1'b1;
        settle(10);
        gtest <= 1'b0;
        settle(10);
    endtask : pulse_test

    task automatic press_start();
        start <= 1'b1;
        settle(5);
        start <= 1'b0;
        settle(4);
    endtask : press_start

    // Hang guard
    initial begin
        repeat (90000) @(posedge sys_clk_i);
        err_total++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        hcode = '{default: CODE_A};
        repeat (3) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        bus_wr(CTRL_OFS, 32'h00000010);
        wait_state(3'h1, 3000);
        chk1("ready_delay", 1'b1, cyc >= 3000 && cyc < 3100);
        meas_green(n);
        chk1("fast_flash", 1'b1, n >= 123 && n <= 127);
        want[0] <= 1'b1;
        wait_state(3'h2, 100);
        t0 = cyc;
        chk_outs(1'b0, 1'b0, 4'h0);
        meas_green(n);
        chk1("slow_flash", 1'b1, n >= 498 && n <= 502);
        wait_state(3'h3, 31000);
        chk1("teach_time", 1'b1,
            cyc - t0 > 59990 && cyc - t0 < 60010);
        chk1("green_off", 1'b0, out_o.led_green);
        chk32("taught", 32'h1, {28'h0, rd_val[11:8]});
        $display("test first teach done");
        power_cycle();
        settle(100);
        chk_outs(1'b0, 1'b0, 4'h0);
        // Count green pulses that show the remaining teach-ins
        n = 0;
        g_prev = 1'b0;
        repeat (2800) begin
            @(posedge sys_clk_i);
            n += int'(out_o.led_green && !g_prev);
            g_prev = out_o.led_green;
        end
        chk32("count_blink", 32'(MAX_TEACH - 1), 32'(n));
        wait_state(3'h4, 3000);
        bus_rd(CODE_OFS);
        chk32("code", {16'h0, CODE_A}, rd_val);
        bus_wr(CTRL_OFS, 32'h00000001);
        for (int r = 0; r < 5; r++) begin
            want[1] <= ROWS[r].h1;
            gtest <= ROWS[r].tst;
            settle(DW + 8);
            chk_outs(ROWS[r].rel, ROWS[r].dg,
                ROWS[r].dm);
            chk1("red", ROWS[r].dg, out_o.led_red);
        end
        $display("test table done");
        bus_wr(CTRL_OFS, 32'h00000005);
        pulse_test();
        chk_outs(1'b0, 1'b0, 4'h3);
        start <= 1'b1;
        settle(10);
        chk1("held_start", 1'b0, out_o.relay_a);
        start <= 1'b0;
        settle(4);
        chk_outs(1'b1, 1'b0, 4'h3);
        bus_wr(CTRL_OFS, 32'h0000000D);
        fb <= 1'b0;
        pulse_test();
        press_start();
        chk1("fb_open_start", 1'b0, out_o.relay_a);
        // Heads stay in range while the loop is open
        fb <= 1'b1;
        press_start();
        chk_outs(1'b1, 1'b0, 4'h3);
        $display("test start modes done");
        bus_wr(CTRL_OFS, 32'h00000001);
        hcode[0] <= CODE_B;
        wait_state(3'h2, 100);
        chk_outs(1'b0, 1'b0, 4'h0);
        want[0] <= 1'b0;
        settle(DW + 8);
        bus_rd(STATUS_OFS);
        chk1("invalid_teach", 1'b1, rd_val[3]);
        chk1("red_invalid", 1'b1, out_o.led_red);
        hcode[0] <= CODE_A;
        want <= 4'h1;
        power_cycle();
        wait_state(3'h4, 3000);
        bus_rd(CODE_OFS);
        chk32("code_kept", {16'h0, CODE_A}, rd_val);
        settle(4);
        chk_outs(1'b1, 1'b0, 4'h1);
        $display("test aborted teach done");
        fault <= 1'b1;
        settle(4);
        chk_outs(1'b0, 1'b1, 4'h1);
        chk1("red_fault", 1'b1, out_o.led_red);
        bus_rd(4'hC);
        chk32("unmapped", 32'h0, rd_val);
        $display("test fault done");
        stop_test();
    end
endmodule : safety_guard_evaluation_ctrl_tb
`default_nettype wire
